// ==== verification/tb.sv ====
// Purpose: self-checking bench of the video byte output port
// Assumes: inputs move 2 ns after the rising edge
// Notes:   factory test pin held low throughout
`timescale 1ns/10ps
module tb;
   logic               clk = 0, rst = 1, srcValid = 0, boardTest = 0, srcRec = 0, srcTrn = 0;
   logic               srcReady, reqN, recN, trnN, oe, ackN, got, sawFull = 0, prevStall = 0;
   logic [7:0]         srcData = 0, dOut, stallPct = 0;
   logic [9:0]         prevVal;
   logic [31:0]        lfsr = 32'h0001_1b2f;
   int                 errCount = 0, nCompared = 0, cycles = 0;
   vbo_pkg::vbo_word_s word, expQ[$];
   vbo_video_port vbo_video_port_i (.clk(clk), .rst(rst), .srcValid(srcValid),
      .srcReady(srcReady), .srcData(srcData), .srcLastRecord(srcRec),
      .srcLastTransfer(srcTrn), .video_byte_valid_n(reqN), .video_sink_ready_n(ackN),
      .video_byte_out(dOut), .record_last_byte_n(recN), .transfer_last_byte_n(trnN),
      .videoPortOe(oe), .board_test_tristate(boardTest),
      .factory_test_input(1'b0));
   vbo_sink_model vbo_sink_model_i (.clk(clk), .rst(rst), .stallPct(stallPct), .reqN(reqN),
      .dataIn(dOut), .recN(recN), .trnN(trnN), .oe(oe), .ackN(ackN), .got(got), .word(word));
   initial forever #12.5 clk = ~clk;
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] nextRand(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // the final word of a batch ends both record and transfer
   function automatic vbo_pkg::vbo_word_s mkWord(input logic [31:0] r, input logic last);
      return '{data: r[7:0], lastRecord: r[8] | last, lastTransfer: last};
   endfunction
   task automatic check(input logic [15:0] act, input logic [15:0] exp);
      nCompared++;
      if (act !== exp) begin
         errCount++;
         $display("ERROR t=%0t got=%h exp=%h", $time, act, exp);
      end
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // reset is long enough and discards any traffic still queued; internal reset releases on the second edge, ready on the third
   task automatic doReset();
      @(posedge clk);
      #2 rst = 1;
      expQ.delete();
      repeat (12) @(posedge clk);
      #2 check({reqN, recN, trnN, srcReady}, 4'he);
      rst = 0;
      repeat (2) @(posedge clk);
      #2 check(srcReady, 1'b0);
      @(posedge clk);
      #2 check(srcReady, 1'b1);
   endtask
   task automatic sendBatch(input int n);
      vbo_pkg::vbo_word_s w;
      // start just after a rising edge, whatever phase the caller ended in
      @(posedge clk);
      #2;
      for (int i = 0; i < n; i++) begin
         lfsr = nextRand(lfsr);
         w = mkWord(lfsr, i == n - 1);
         srcValid = 1;
         {srcData, srcRec, srcTrn} = w;
         @(posedge clk);
         while (srcReady !== 1'b1) @(posedge clk);
         expQ.push_back(w);
         #2;
      end
      srcValid = 0;
   endtask
   task automatic drain();
      for (int k = 0; k < 2000 && expQ.size() != 0; k++) @(negedge clk);
      check(16'(expQ.size()), 16'h0000);
      repeat (3) @(negedge clk);
      check({reqN, recN, trnN}, 3'h7);
   endtask
   // ----------------------------------------------------------
   // monitors: received words, stalled stability, refusal seen
   // ----------------------------------------------------------
   always @(negedge clk) begin
      if (got === 1'b1) begin
         // a byte nobody sent can never match an all-ones 16-bit value
         if (expQ.size() == 0) check({6'h00, word}, 16'hffff);
         else check(word, expQ.pop_front());
      end
      // a reset in between legally clears the stalled byte
      if (prevStall && !rst) check({dOut, recN, trnN}, prevVal);
      prevStall = !rst && reqN === 1'b0 && ackN === 1'b1 && oe === 1'b1;
      prevVal = {dOut, recN, trnN};
      if (srcValid && srcReady === 1'b0 && !rst) sawFull = 1;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errCount++;
         $display("ERROR t=%0t timeout %h %h", $time, cycles, 20000);
         summarize();
      end
   end
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      doReset();
      sendBatch(40);
      drain();
      $display("test stream done");
      stallPct = 8'h3c;
      sendBatch(40);
      drain();
      check(sawFull, 1'b1);
      $display("test stall done");
      // acknowledge always low, so exactly two bytes pass before the enable drops
      stallPct = 8'h00;
      @(posedge clk);
      #2 boardTest = 1;
      fork
         sendBatch(6);
         begin
            repeat (8) @(negedge clk);
            check(oe, 1'b0);
            check(16'(expQ.size()), 16'h0003);
            @(posedge clk);
            #2 boardTest = 0;
            repeat (8) @(negedge clk);
            check(oe, 1'b1);
         end
      join
      drain();
      $display("test board test done");
      stallPct = 8'h80;
      sendBatch(2);
      doReset();
      stallPct = 8'h1e;
      sendBatch(20);
      drain();
      $display("test reset mid run done");
      summarize();
   end
endmodule // tb

// ==== verification/vbo_sink_model.sv ====
// Purpose: consumer on the far side of the video byte port
// Assumes: shares clk with the port; acknowledge moves 2 ns after the edge
// Notes:   stallPct of 8'h80 withholds acknowledge always, 0 never
`timescale 1ns/10ps
module vbo_sink_model (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic [7:0]         stallPct,
   input  wire logic               reqN,
   input  wire logic [7:0]         dataIn,
   input  wire logic               recN,
   input  wire logic               trnN,
   input  wire logic               oe,
   output      logic               ackN,
   output      logic               got,
   output      vbo_pkg::vbo_word_s word
);
   logic [31:0] rnd = 32'h0001_1b2f;
   // ----------------------------------------------------------
   // take a byte only when request and acknowledge meet low
   // ----------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ackN <= 1'b1;
         got  <= 1'b0;
      end else begin
         got  <= !reqN && !ackN && oe; // sampled on the rising edge
         // a tristated port shows garbage here, never the last driven value
         word <= '{data: oe ? dataIn : ~dataIn, lastRecord: oe ? !recN : recN,
                   lastTransfer: oe ? !trnN : trnN};
         rnd  <= {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
         // ready is offered independently of request, stalls at random
         ackN <= #2 ({1'b0, rnd[6:0]} < stallPct);
      end
   end
endmodule // vbo_sink_model

// ==== verilog/vbo_pkg.sv ====
// Purpose: types shared by the video output port
// Assumes: nothing beyond the constants header
// Notes:   one buffered word is a byte plus its two end markers
package vbo_pkg;

   // -----------------------------------------------------------------
   // buffered word
   // -----------------------------------------------------------------
   typedef logic [7:0] vbo_byte_t;

   typedef struct packed {
      vbo_byte_t data;
      logic      lastRecord;
      logic      lastTransfer;
   } vbo_word_s;

endpackage

// ==== verilog/vbo_regs.svh ====
// Purpose: constants of the byte-wide video output port
// Assumes: included by bare name from the port module
// Notes:   no offsets exist, the port has no software registers
`ifndef VBO_REGS_SVH
`define VBO_REGS_SVH

// -----------------------------------------------------------------
// widths and depths
// -----------------------------------------------------------------
`define VBO_BYTE_W        8
`define VBO_BUF_DEPTH     2

// -----------------------------------------------------------------
// reset and idle levels
// -----------------------------------------------------------------
`define VBO_RST_MIN_CLKS  10
`define VBO_MARK_IDLE     1'b1
`define VBO_MARK_SET      1'b0
`define VBO_RST_ON        1'b1
`define VBO_RST_OFF       1'b0
`define VBO_OE_ON         1'b1
`define VBO_OE_OFF        1'b0
`define VBO_TEST_IDLE     1'b0
`define VBO_BYTE_RST      8'h00

`endif

// ==== verilog/vbo_video_port.sv ====
// Purpose: byte-wide video output port with request/acknowledge handshake
// Assumes: consumer runs on clk; board-test and factory-test pins are async
// Notes:   a two-entry buffer sits between the engine and the output stage
//
// Contract
// - request low only while byte is valid
// - both low at edge transfers, then advance
// - record-end marker only with record's last byte
// - transfer-end marker only with transfer's last byte
// - async reset synchronised to rising clock edge
// - board-test high tristates every output (the port holds the enable on while reset is active)
`timescale 1ns/10ps
`include "vbo_regs.svh"

module vbo_video_port #(
   parameter int DEPTH = `VBO_BUF_DEPTH
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   srcValid,
   output      logic                   srcReady,
   input  wire logic [`VBO_BYTE_W-1:0] srcData,
   input  wire logic                   srcLastRecord,
   input  wire logic                   srcLastTransfer,
   output      logic                   video_byte_valid_n,
   input  wire logic                   video_sink_ready_n,
   output      logic [`VBO_BYTE_W-1:0] video_byte_out,
   output      logic                   record_last_byte_n,
   output      logic                   transfer_last_byte_n,
   output      logic                   videoPortOe,
   input  wire logic                   board_test_tristate,
   input  wire logic                   factory_test_input
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
   localparam logic [PTR_W-1:0] PTR_ZERO = '0;

   // wrap a buffer pointer; used for both the write and the read side
   function automatic logic [PTR_W-1:0] ptrNext(input logic [PTR_W-1:0] p);
      ptrNext = (p == PTR_W'(DEPTH - 1)) ? PTR_ZERO : p + PTR_W'(1);
   endfunction

   // -----------------------------------------------------------------
   // reset synchroniser
   // -----------------------------------------------------------------
   logic rstMeta;
   logic intRst;

   // assert at once, release only on a rising edge so no flop sees a runt
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rstMeta <= `VBO_RST_ON;
         intRst  <= `VBO_RST_ON;
      end else begin
         rstMeta <= `VBO_RST_OFF;
         intRst  <= rstMeta;
      end
   end

   // -----------------------------------------------------------------
   // asynchronous test pins: three flops, change once last two agree
   // -----------------------------------------------------------------
   logic [2:0] tstShift;
   logic [2:0] facShift;
   logic       testState;
   logic       factoryHold;

   // the first stage feeds only the second, the filter reads stages two and three
   always_ff @(posedge clk or posedge intRst) begin
      if (intRst) begin
         tstShift    <= '0;
         facShift    <= '0;
         testState   <= `VBO_TEST_IDLE;
         factoryHold <= `VBO_TEST_IDLE;
      end else begin
         tstShift <= {tstShift[1:0], board_test_tristate};
         facShift <= {facShift[1:0], factory_test_input};
         if (tstShift[1] == tstShift[2]) begin
            testState <= tstShift[2];
         end
         if (facShift[1] == facShift[2]) begin
            factoryHold <= facShift[2];
         end
      end
   end

   // -----------------------------------------------------------------
   // output enable
   // -----------------------------------------------------------------
   // one enable covers all port outputs; the pad ring applies it
   always_ff @(posedge clk or posedge intRst) begin
      if (intRst) begin
         videoPortOe <= `VBO_OE_ON;
      end else begin
         videoPortOe <= ~testState;
      end
   end

   // -----------------------------------------------------------------
   // two-entry buffer
   // -----------------------------------------------------------------
   vbo_pkg::vbo_word_s mem [DEPTH];
   logic [PTR_W-1:0]   wrPtr;
   logic [PTR_W-1:0]   rdPtr;
   logic [CNT_W-1:0]   count;
   vbo_pkg::vbo_word_s head;
   vbo_pkg::vbo_word_s inWord;
   logic               push;
   logic               pop;
   logic               bufNotEmpty;
   logic [CNT_W-1:0]   next_count;

   // decode of buffer moves
   assign inWord      = '{data: srcData, lastRecord: srcLastRecord,
                          lastTransfer: srcLastTransfer};
   assign push        = srcValid & srcReady;
   assign bufNotEmpty = (count != CNT_ZERO);
   assign head        = mem[rdPtr];
   assign next_count  = (push & ~pop) ? count + CNT_ONE :
                        (pop & ~push) ? count - CNT_ONE : count;

   // storage has no reset; only written entries are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inWord;
      end
   end

   // ready is registered, so it looks one cycle ahead through next_count
   always_ff @(posedge clk or posedge intRst) begin
      if (intRst) begin
         wrPtr    <= PTR_ZERO;
         rdPtr    <= PTR_ZERO;
         count    <= CNT_ZERO;
         srcReady <= 1'b0;
      end else begin
         if (push) begin
            wrPtr <= ptrNext(wrPtr);
         end
         if (pop) begin
            rdPtr <= ptrNext(rdPtr);
         end
         count    <= next_count;
         srcReady <= (next_count != CNT_FULL);
      end
   end

   // -----------------------------------------------------------------
   // output stage and handshake
   // -----------------------------------------------------------------
   logic taken;
   logic outFree;
   logic loadOut;

   // a transfer needs request and acknowledge low at one edge, pins driven;
   // acknowledge is same-clock logic so it is sampled without a synchroniser
   assign taken   = ~video_byte_valid_n & ~video_sink_ready_n & videoPortOe;
   assign outFree = video_byte_valid_n | taken;
   // factory test freezes the port rather than emit bytes it cannot vouch for
   assign loadOut = outFree & bufNotEmpty & ~factoryHold;
   assign pop     = loadOut;

   // stage only changes on a free slot, which holds a stalled byte still
   always_ff @(posedge clk or posedge intRst) begin
      if (intRst) begin
         video_byte_valid_n   <= `VBO_MARK_IDLE;
         video_byte_out       <= `VBO_BYTE_RST;
         record_last_byte_n   <= `VBO_MARK_IDLE;
         transfer_last_byte_n <= `VBO_MARK_IDLE;
      end else if (loadOut) begin
         video_byte_valid_n   <= `VBO_MARK_SET;
         video_byte_out       <= head.data;
         record_last_byte_n   <= ~head.lastRecord;
         transfer_last_byte_n <= ~head.lastTransfer;
      end else if (outFree) begin
         video_byte_valid_n   <= `VBO_MARK_IDLE;
         record_last_byte_n   <= `VBO_MARK_IDLE;
         transfer_last_byte_n <= `VBO_MARK_IDLE;
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   sequence s_stall;
      ~video_byte_valid_n & video_sink_ready_n;
   endsequence

   sequence s_hold;
      $stable(video_byte_out) & $stable(record_last_byte_n)
         & $stable(transfer_last_byte_n) & ~video_byte_valid_n;
   endsequence

   sequence s_rst_release;
      intRst ##1 intRst ##1 !intRst;
   endsequence

   req_cause_a: assert property (@(posedge clk) disable iff (intRst)
      $fell(video_byte_valid_n) |-> $past(loadOut))
      else $error("request fell without a byte loaded");

   xfer_adv_a: assert property (@(posedge clk) disable iff (intRst)
      (taken & bufNotEmpty & ~factoryHold) |=>
         (~video_byte_valid_n & video_byte_out == $past(head.data)))
      else $error("port did not advance after a transfer");

   eor_mark_a: assert property (@(posedge clk) disable iff (intRst)
      loadOut |=> (record_last_byte_n == ~$past(head.lastRecord)))
      else $error("record marker does not match its byte");

   eot_mark_a: assert property (@(posedge clk) disable iff (intRst)
      (video_byte_valid_n |-> (record_last_byte_n & transfer_last_byte_n))
      and (loadOut |=> (transfer_last_byte_n == ~$past(head.lastTransfer))))
      else $error("transfer marker wrong or shown without a byte");

   rst_sync_a: assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> s_rst_release)
      else $error("internal reset not released two edges after pin");

   tri_out_a: assert property (@(posedge clk) disable iff (intRst)
      (testState |=> ~videoPortOe) and (~testState |=> videoPortOe))
      else $error("output enable does not follow board test");

   stall_hold_a: assert property (@(posedge clk) disable iff (intRst)
      s_stall |=> s_hold)
      else $error("stalled byte or marker changed");

   edge_launch_a: assert property (@(posedge clk) disable iff (intRst)
      $changed(video_byte_out) |-> $past(loadOut) ##0 $past(outFree))
      else $error("output byte changed without a free slot");

endmodule // vbo_video_port
